// ==== rtl/sps_defs.svh ====
// Register offsets, field positions, reset values for the output-four (six-input) or output-two (four-input)
// product-one dependency mask. Included by the package and the main module.
`ifndef SPS_DEFS_SVH
`define SPS_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SPS_OFF_PRI_WD      8'h1D
`define SPS_OFF_SEC_LOGIC   8'h1E
`define SPS_OFF_LOGIC_OUT   8'h1F
`define SPS_OFF_OUT8        8'h23
`define SPS_OFF_MR          8'h40

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SPS_BIT_OUT8        0
`define SPS_BIT_MR          3

// ----------------------------------------------------------------------
// Reset values and variant masks
// ----------------------------------------------------------------------
`define SPS_RST_BYTE        8'h00
`define SPS_FOUR_MASK_1D    8'hCF
`define SPS_FOUR_MASK_1E    8'hCF
`define SPS_FOUR_MASK_1F    8'hF3
`define SPS_COND_W          25

`endif

// ==== rtl/sps_pkg.sv ====
// Types shared by the dependency mask block.
// Assumes sps_defs.svh on the include path.
`include "sps_defs.svh"

package sps_pkg;

  // --------------------------------------------------------------------
  // Condition vector, laid out as the select registers concatenate
  // --------------------------------------------------------------------
  typedef struct packed {
    logic       peer8;
    logic [3:0] peer_hi;
    logic [1:0] peer_lo;
    logic [3:0] gpi;
    logic [5:0] sec;
    logic [1:0] wd;
    logic [5:0] pri;
  } sps_cond_t;

  // --------------------------------------------------------------------
  // Monitored fault status, high means fault
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [5:0] pri_fault;
    logic [5:0] sec_fault;
    logic [1:0] wd_fault;
  } sps_mon_t;

  // --------------------------------------------------------------------
  // Byte register access request
  // --------------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sps_reg_req_t;

endpackage : sps_pkg

// ==== rtl/sps_product_term.sv ====
// Product term evaluator: AND of the healthy state of every selected condition, empty_val_i when none is selected.
// Assumes select and healthy vectors of equal width, combinational use.
`timescale 1ns/1ps

module sps_product_term #(
  parameter int N = 25
) (
  input  wire logic [N-1:0] sel_i,
  input  wire logic [N-1:0] healthy_i,
  input  wire logic         empty_val_i,
  output logic              product_o,
  output logic              empty_o
);

  // --------------------------------------------------------------------
  // Elaboration check
  // --------------------------------------------------------------------
  if (N < 1) begin : g_bad_n
    $error("sps_product_term: N must be at least 1");
  end

  // --------------------------------------------------------------------
  // Evaluation
  // --------------------------------------------------------------------
  always_comb begin
    empty_o = (sel_i == '0);
    // Unselected conditions are forced healthy
    if (sel_i == '0) begin
      product_o = empty_val_i;
    end else begin
      product_o = &(healthy_i | ~sel_i);
    end
  end

endmodule : sps_product_term

// ==== rtl/sps_dep_mask.sv ====
// Product-one dependency mask of one sequenced output, with its byte registers.
// Assumes a byte register port fed by the serial interface, one clock, and
// product two supplied by a neighbouring block.
`timescale 1ns/1ps

`include "sps_defs.svh"

module sps_dep_mask
  import sps_pkg::*;
#(
  parameter bit SIX_INPUT   = 1'b1,
  parameter bit EMPTY_VALUE = 1'b1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire sps_reg_req_t reg_req_i,
  output logic [7:0]        reg_rdata_o,
  output logic              reg_rvalid_o,
  input  wire sps_mon_t     mon_i,
  input  wire logic [3:0]   logic_input_ok_i,
  input  wire logic [8:1]   peer_asserted_i,
  input  wire logic         manual_reset_n_i,
  input  wire logic         product2_i,
  output logic              product1_o,
  output logic              seq_output_asserted_o
);

  // --------------------------------------------------------------------
  // Elaboration check
  // --------------------------------------------------------------------
  if ($bits(sps_cond_t) != `SPS_COND_W) begin : g_bad_cond
    $error("sps_dep_mask: condition vector width mismatch");
  end

  // --------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
    addr_hit = (a == off);
  endfunction : addr_hit

  // Peer output numbers for bits 4-7 of the output select byte
  function automatic logic [3:0] peer_hi_healthy(input logic [8:1] asrt);
    if (SIX_INPUT) begin
      peer_hi_healthy = ~{asrt[7], asrt[6], asrt[5], asrt[3]};
    end else begin
      peer_hi_healthy = ~{asrt[5], asrt[4], asrt[3], asrt[1]};
    end
  endfunction : peer_hi_healthy

  // --------------------------------------------------------------------
  // Select registers
  // --------------------------------------------------------------------
  logic [7:0] pri_wd_sel_ff;
  logic [7:0] sec_logic_sel_ff;
  logic [7:0] logic_out_sel_ff;
  logic [7:0] out8_sel_ff;
  logic [7:0] mr_sel_ff;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pri_wd_sel_ff    <= `SPS_RST_BYTE;
      sec_logic_sel_ff <= `SPS_RST_BYTE;
      logic_out_sel_ff <= `SPS_RST_BYTE;
      out8_sel_ff      <= `SPS_RST_BYTE;
      mr_sel_ff        <= `SPS_RST_BYTE;
    end else if (reg_req_i.wr) begin
      if (addr_hit(reg_req_i.addr, `SPS_OFF_PRI_WD)) begin
        pri_wd_sel_ff <= reg_req_i.wdata;
      end
      if (addr_hit(reg_req_i.addr, `SPS_OFF_SEC_LOGIC)) begin
        sec_logic_sel_ff <= reg_req_i.wdata;
      end
      if (addr_hit(reg_req_i.addr, `SPS_OFF_LOGIC_OUT)) begin
        logic_out_sel_ff <= reg_req_i.wdata;
      end
      if (addr_hit(reg_req_i.addr, `SPS_OFF_OUT8)) begin
        out8_sel_ff <= reg_req_i.wdata;
      end
      if (addr_hit(reg_req_i.addr, `SPS_OFF_MR)) begin
        mr_sel_ff <= reg_req_i.wdata;
      end
    end
  end

  // --------------------------------------------------------------------
  // Register read
  // --------------------------------------------------------------------
  logic [7:0] nxt_rdata;

  always_comb begin
    nxt_rdata = 8'h00;
    unique case (reg_req_i.addr)
      `SPS_OFF_PRI_WD:    nxt_rdata = pri_wd_sel_ff;
      `SPS_OFF_SEC_LOGIC: nxt_rdata = sec_logic_sel_ff;
      `SPS_OFF_LOGIC_OUT: nxt_rdata = logic_out_sel_ff;
      `SPS_OFF_OUT8:      nxt_rdata = out8_sel_ff;
      `SPS_OFF_MR:        nxt_rdata = mr_sel_ff;
      default:            nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_req_i.rd;
      if (reg_req_i.rd) begin
        reg_rdata_o <= nxt_rdata;
      end
    end
  end

  // --------------------------------------------------------------------
  // Effective selection, six-input-only bits ignored on the small variant
  // --------------------------------------------------------------------
  logic [7:0] eff_1d;
  logic [7:0] eff_1e;
  logic [7:0] eff_1f;
  logic       eff_out8;
  sps_cond_t  sel;
  sps_cond_t  healthy;

  always_comb begin
    eff_1d   = pri_wd_sel_ff;
    eff_1e   = sec_logic_sel_ff;
    eff_1f   = logic_out_sel_ff;
    eff_out8 = out8_sel_ff[`SPS_BIT_OUT8];
    if (!SIX_INPUT) begin
      eff_1d   = pri_wd_sel_ff & `SPS_FOUR_MASK_1D;
      eff_1e   = sec_logic_sel_ff & `SPS_FOUR_MASK_1E;
      eff_1f   = logic_out_sel_ff & `SPS_FOUR_MASK_1F;
      eff_out8 = 1'b0;
    end
    sel = sps_cond_t'({eff_out8, eff_1f, eff_1e, eff_1d});
  end

  // Healthy view of each condition, in the same bit order
  always_comb begin
    healthy.pri     = ~mon_i.pri_fault;
    healthy.wd      = ~mon_i.wd_fault;
    healthy.sec     = ~mon_i.sec_fault;
    healthy.gpi     = logic_input_ok_i;
    healthy.peer_lo = ~peer_asserted_i[2:1];
    healthy.peer_hi = peer_hi_healthy(peer_asserted_i);
    healthy.peer8   = ~peer_asserted_i[8];
  end

  // --------------------------------------------------------------------
  // Product one
  // --------------------------------------------------------------------
  logic p1_comb;
  logic p1_empty;

  sps_product_term #(
    .N (`SPS_COND_W)
  ) u_product1 (
    .sel_i       (sel),
    .healthy_i   (healthy),
    .empty_val_i (EMPTY_VALUE),
    .product_o   (p1_comb),
    .empty_o     (p1_empty)
  );

  // --------------------------------------------------------------------
  // Output state: output four on six-input, output two on four-input
  // --------------------------------------------------------------------
  logic mr_force;
  logic nxt_asserted;

  assign mr_force     = mr_sel_ff[`SPS_BIT_MR] && !manual_reset_n_i;
  assign nxt_asserted = mr_force || !(p1_comb || product2_i);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      product1_o            <= 1'b0;
      seq_output_asserted_o <= 1'b1;
    end else begin
      product1_o            <= p1_comb;
      seq_output_asserted_o <= nxt_asserted;
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  // Holds assertions off on the edge that releases reset
  logic rst_done_ff;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_done_ff <= 1'b0;
    end else begin
      rst_done_ff <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i || !rst_done_ff);

  sequence s_write_1d;
    reg_req_i.wr && addr_hit(reg_req_i.addr, `SPS_OFF_PRI_WD);
  endsequence

  sequence s_read_1d;
    reg_req_i.rd && !reg_req_i.wr && addr_hit(reg_req_i.addr, `SPS_OFF_PRI_WD);
  endsequence

  sequence s_mr_held;
    mr_sel_ff[`SPS_BIT_MR] && !manual_reset_n_i;
  endsequence

  sequence s_mr_let_go;
    manual_reset_n_i && product2_i;
  endsequence

  a_pri_fault_dep: assert property (
    (pri_wd_sel_ff[0] && mon_i.pri_fault[0]) |=> !product1_o)
    else $error("selected primary fault did not clear product one");

  a_four_mask: assert property (
    !SIX_INPUT |-> (sel.pri[5:4] == 2'b00 && sel.peer_lo == 2'b00 && !sel.peer8))
    else $error("six-input-only select reached product on small variant");

  a_wd_dep: assert property (
    (pri_wd_sel_ff[7] && mon_i.wd_fault[1]) |-> !p1_comb)
    else $error("selected watchdog fault did not clear product one");

  a_sec_dep: assert property (
    (sec_logic_sel_ff[1] && mon_i.sec_fault[1]) |=> !product1_o)
    else $error("selected secondary fault did not clear product one");

  a_logic_dep: assert property (
    (logic_out_sel_ff[1] && !logic_input_ok_i[3]) |-> !p1_comb)
    else $error("selected logic input did not clear product one");

  a_peer_dep: assert property (
    (logic_out_sel_ff[4] && peer_asserted_i[SIX_INPUT ? 3 : 1]) |-> !p1_comb)
    else $error("selected peer output did not clear product one");

  a_mr_force: assert property (
    (mr_sel_ff[`SPS_BIT_MR] && !manual_reset_n_i) |=> seq_output_asserted_o)
    else $error("manual reset did not assert the output");

  a_unselected_free: assert property (
    (!pri_wd_sel_ff[0] && $stable(sel) && $stable(healthy.wd) && $stable(healthy.sec)
      && $stable(healthy.gpi) && $stable(healthy.peer_lo) && $stable(healthy.peer_hi)
      && $stable(healthy.peer8) && $stable(healthy.pri[5:1])) |-> $stable(p1_comb))
    else $error("unselected primary fault changed product one");

  a_product_deassert: assert property (
    (!mr_force && (p1_comb || product2_i)) |=> !seq_output_asserted_o)
    else $error("output stayed asserted with a true product");

  a_product_assert: assert property (
    (!p1_comb && !product2_i) |=> seq_output_asserted_o)
    else $error("output not asserted with both products false");

  a_empty_product: assert property (
    p1_empty |=> product1_o == EMPTY_VALUE)
    else $error("empty product did not take its constant");

  a_reg_readback: assert property (
    s_write_1d ##1 s_read_1d |=> reg_rvalid_o && reg_rdata_o == $past(pri_wd_sel_ff))
    else $error("select byte read back wrong value");

  a_pri_hi_dep: assert property (
    (SIX_INPUT && pri_wd_sel_ff[5] && mon_i.pri_fault[5]) |-> !p1_comb)
    else $error("selected monitor six fault did not clear product one");

  a_gpi_lo_dep: assert property (
    (sec_logic_sel_ff[6] && !logic_input_ok_i[0]) |-> !p1_comb)
    else $error("selected logic input one did not clear product one");

  a_peer_lo_dep: assert property (
    (SIX_INPUT && logic_out_sel_ff[2] && peer_asserted_i[1]) |-> !p1_comb)
    else $error("selected output one did not clear product one");

  a_out8_dep: assert property (
    (SIX_INPUT && out8_sel_ff[`SPS_BIT_OUT8] && peer_asserted_i[8]) |-> !p1_comb)
    else $error("selected output eight did not clear product one");

  a_mr_release: assert property (
    s_mr_held ##1 s_mr_let_go |=> !seq_output_asserted_o)
    else $error("output stayed asserted after manual reset let go");

  a_rvalid_pulse: assert property (
    reg_rvalid_o == $past(reg_req_i.rd))
    else $error("read valid not one cycle after read");

endmodule : sps_dep_mask

// ==== testbench/sps_dep_mask_bench.sv ====
// Self-checking bench for the product-one dependency mask, both variants.
// Assumes sps_pkg and sps_dep_mask compiled first, sps_defs.svh on the path.
`timescale 1ns/1ps

module sps_dep_mask_bench
  import sps_pkg::*;
;
  logic         clk_i;
  logic         rst_b_i;
  sps_reg_req_t reg_req_i;
  logic [25:0]  bad;
  logic         manual_reset_n_i;
  logic         product2_i;
  logic [7:0]   rd6, rd4;
  logic         rv6, rv4, p1_6, p1_4, out6, out4;
  logic [31:0]  sel;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp_rd;
  } sps_reg_row_t;
  // Register rows: address, byte written, byte read back
  sps_reg_row_t reg_rows [6] = '{
    '{8'h1d, 8'hb8, 8'hb8},
    '{8'h1e, 8'hbb, 8'hbb},
    '{8'h1f, 8'hba, 8'hba},
    '{8'h23, 8'h86, 8'h86},
    '{8'h40, 8'he5, 8'he5},
    '{8'h41, 8'hff, 8'h00}
  };
  int           err_total = 0;
  int           compares = 0;

  // ----------------------------------------------------------------------
  // Clock and both variants on shared stimulus
  // ----------------------------------------------------------------------
  initial clk_i = 1'b0;
  always #50 clk_i = ~clk_i;

  sps_dep_mask #(.SIX_INPUT(1'b1)) sps_dep_mask_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_req_i(reg_req_i),
    .reg_rdata_o(rd6), .reg_rvalid_o(rv6), .mon_i(sps_mon_t'(bad[13:0])),
    .logic_input_ok_i(~bad[17:14]), .peer_asserted_i(bad[25:18]),
    .manual_reset_n_i(manual_reset_n_i), .product2_i(product2_i),
    .product1_o(p1_6), .seq_output_asserted_o(out6));

  sps_dep_mask #(.SIX_INPUT(1'b0)) sps_dep_mask_inst_four (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_req_i(reg_req_i),
    .reg_rdata_o(rd4), .reg_rvalid_o(rv4), .mon_i(sps_mon_t'(bad[13:0])),
    .logic_input_ok_i(~bad[17:14]), .peer_asserted_i(bad[25:18]),
    .manual_reset_n_i(manual_reset_n_i), .product2_i(product2_i),
    .product1_o(p1_4), .seq_output_asserted_o(out4));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic settle();
    repeat (3) @(posedge clk_i);
    #1;
  endtask : settle

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_req_i <= {1'b1, 1'b0, a, d};
    @(posedge clk_i);
    reg_req_i <= '0;
  endtask : reg_wr

  // Read both instances, rvalid looked at in its one cycle
  task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    reg_req_i <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clk_i);
    reg_req_i <= '0;
    #1;
    chk("rvalid", 8'h01, {7'h00, rv6 & rv4});
    chk("rdata six", exp, rd6);
    chk("rdata four", exp, rd4);
    @(posedge clk_i);
    #1;
    chk("rvalid low", 8'h00, {7'h00, rv6 | rv4});
  endtask : reg_chk

  task automatic set_sel(input logic [31:0] s);
    reg_wr(8'h1d, s[7:0]);
    reg_wr(8'h1e, s[15:8]);
    reg_wr(8'h1f, s[23:16]);
    reg_wr(8'h23, s[31:24]);
  endtask : set_sel

  task automatic out_chk(input logic e);
    settle();
    chk("out six", {7'h00, e}, {7'h00, out6});
    chk("out four", {7'h00, e}, {7'h00, out4});
  endtask : out_chk

  // Expected product one from the selected healthy conditions
  function automatic logic ref_p1(input bit six, input logic [31:0] s, input logic [25:0] b);
    logic [24:0] h;
    logic [24:0] m;
    logic [8:1]  pb;
    pb = b[25:18];
    h = {~pb[8], six ? ~{pb[7], pb[6], pb[5], pb[3]} : ~{pb[5], pb[4], pb[3], pb[1]},
         ~pb[2:1], ~b[17:14], ~b[7:2], ~b[1:0], ~b[13:8]};
    m = six ? s[24:0] : s[24:0] & ~25'h10c_3030;
    return (m == '0) ? 1'b1 : &(h | ~m);
  endfunction : ref_p1

  // ----------------------------------------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------------------------------------
  initial begin
    #(10000 * 100);
    err_total++;
    test_done();
  end

  initial begin
    rst_b_i = 1'b0;
    reg_req_i = '0;
    bad = '0;
    manual_reset_n_i = 1'b1;
    product2_i = 1'b0;
    repeat (10) @(posedge clk_i);
    #1;
    chk("reset out", 8'h01, {7'h00, out6 & out4});
    @(posedge clk_i) rst_b_i <= 1'b1;
    settle();
    chk("empty p1", 8'h01, {7'h00, p1_6 & p1_4});
    out_chk(1'b0);
    $display("test reset done");
    foreach (reg_rows[k]) begin
      reg_chk(reg_rows[k].addr, 8'h00);
      reg_wr(reg_rows[k].addr, reg_rows[k].wdata);
      reg_chk(reg_rows[k].addr, reg_rows[k].exp_rd);
    end
    // Write then read in the very next cycle
    @(posedge clk_i) reg_req_i <= {1'b1, 1'b0, 8'h1d, 8'h3c};
    @(posedge clk_i) reg_req_i <= {1'b0, 1'b1, 8'h1d, 8'h00};
    @(posedge clk_i) reg_req_i <= '0;
    #1;
    chk("b2b rdata six", 8'h3c, rd6);
    chk("b2b rdata four", 8'h3c, rd4);
    $display("test registers done");
    for (int i = 0; i < 25; i++) begin
      sel = 32'h1 << i;
      set_sel(sel);
      for (int j = 0; j < 26; j++) begin
        @(posedge clk_i) bad <= 26'h1 << j;
        settle();
        chk("p1 six", ref_p1(1'b1, sel, bad), p1_6);
        chk("p1 four", ref_p1(1'b0, sel, bad), p1_4);
      end
    end
    $display("test condition map done");
    set_sel(32'h0000_0001);
    @(posedge clk_i) bad <= 26'h000_0100;
    out_chk(1'b1);
    @(posedge clk_i) product2_i <= 1'b1;
    out_chk(1'b0);
    reg_wr(8'h40, 8'h08);
    @(posedge clk_i) manual_reset_n_i <= 1'b0;
    out_chk(1'b1);
    @(posedge clk_i) manual_reset_n_i <= 1'b1;
    out_chk(1'b0);
    @(posedge clk_i) manual_reset_n_i <= 1'b0;
    out_chk(1'b1);
    reg_wr(8'h40, 8'h00);
    out_chk(1'b0);
    @(posedge clk_i) manual_reset_n_i <= 1'b1;
    $display("test output done");
    @(posedge clk_i) rst_b_i <= 1'b0;
    #1;
    chk("mid reset out", 8'h01, {7'h00, out6 & out4});
    @(posedge clk_i) rst_b_i <= 1'b1;
    reg_chk(8'h1d, 8'h00);
    $display("test mid reset done");
    test_done();
  end
endmodule : sps_dep_mask_bench
